// ==== hdl/bmo_consts.vh ====
/*
  Constants for the output-advance and bit-error test block: register
  offsets, field positions, reset values and timing counts.
  Assumes a 250 MHz core clock and a 16-bit register port.
*/
// Behaviour
// - two-bit code advances each local output
// - advance fixed in ns, so scales with rate
// - local select bits 11..8 name stream
// - local select bits 7..0 name channel
// - local error count sixteen bits, saturating
// - backplane select at 0x29, stream 12..8
// - backplane select bits 7..0 name channel
// - backplane error count read-only, saturating
// - two-bit code advances each backplane output
`ifndef BMO_CONSTS_VH
`define BMO_CONSTS_VH

// register offsets
`define BMO_OFS_BP_ADV0      8'h1c
`define BMO_OFS_BP_ADV1      8'h1d
`define BMO_OFS_BP_ADV2      8'h1e
`define BMO_OFS_BP_ADV3      8'h1f
`define BMO_OFS_LOC_ADV_LO   8'h20
`define BMO_OFS_LOC_ADV_HI   8'h21
`define BMO_OFS_LOC_SEL      8'h26
`define BMO_OFS_LOC_ERR      8'h27
`define BMO_OFS_BP_SEL       8'h29
`define BMO_OFS_BP_ERR       8'h2a

// storage slots of the writable registers
`define BMO_SLOT_LOC_ADV_LO  3'h0
`define BMO_SLOT_LOC_ADV_HI  3'h1
`define BMO_SLOT_BP_ADV0     3'h2
`define BMO_SLOT_LOC_SEL     3'h6
`define BMO_SLOT_BP_SEL      3'h7

// select register fields
`define BMO_LOC_STREAM_MSB   11
`define BMO_LOC_STREAM_LSB   8
`define BMO_BP_STREAM_MSB    12
`define BMO_BP_STREAM_LSB    8
`define BMO_CHAN_MSB         7
`define BMO_CHAN_LSB         0
`define BMO_LOC_SEL_MASK     16'h0fff
`define BMO_BP_SEL_MASK      16'h1fff

// reset values
`define BMO_RESET_WORD       16'h0000
`define BMO_ERR_MAX          16'hffff

// timing
`define BMO_CLK_PERIOD_PS    4000
`define BMO_ADV_STEP_PS      7500
`define BMO_ADV_STEP_CYC     ((`BMO_ADV_STEP_PS + `BMO_CLK_PERIOD_PS / 2) / `BMO_CLK_PERIOD_PS)
`define BMO_ADV_LEAD_CYC     (3 * `BMO_ADV_STEP_CYC)

`endif

// ==== hdl/bmo_regmem.v ====
/*
  Small register store for the writable words of the block, with a
  synchronous reset and a registered read port.
  Assumes one write and one read per cycle, both on the core clock.
*/
`include "bmo_consts.vh"

module bmo_regmem (
  // clock and reset
  input  wire        clock_i,
  input  wire        reset_n_i,
  // write port
  input  wire        wr_i,
  input  wire [2:0]  wr_slot_i,
  input  wire [15:0] wr_data_i,
  // read port
  input  wire [2:0]  rd_slot_i,
  output reg  [15:0] rd_data_o
);

  reg [15:0] mem [0:7];
  integer    k;

  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      for (k = 0; k < 8; k = k + 1) begin
        mem[k] <= `BMO_RESET_WORD;
      end
      rd_data_o <= `BMO_RESET_WORD;
    end else begin
      if (wr_i) begin
        mem[wr_slot_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_slot_i];
    end
  end

endmodule // bmo_regmem

// ==== hdl/bmo_top.v ====
/*
  Per-stream output advancement for 16 local and 32 backplane output
  streams, and the bit-error test path that counts pattern errors on one
  selected local and one selected backplane channel.
  Assumes the frame timing, bit strobes, channel counters and expected
  pattern bits come from logic on the same clock; serial input data come
  from pins and are synchronised here.
*/
// The plain strobed port was decided locally.
`include "bmo_consts.vh"

module bmo_top (
  // clock and reset
  input  wire        CLOCK_I,
  input  wire        RESET_N_I,
  // register port
  input  wire [7:0]  REG_ADDR_I,
  input  wire [15:0] REG_WDATA_I,
  input  wire        REG_WR_I,
  input  wire        REG_RD_I,
  output reg  [15:0] REG_RDATA_O,
  // frame timing
  input  wire        FRAME_EARLY_I,
  output reg  [15:0] LOCAL_FRAME_O,
  output reg  [31:0] BP_FRAME_O,
  // local test path
  input  wire [15:0] LOCAL_RX_I,
  input  wire        LOCAL_BIT_STB_I,
  input  wire [7:0]  LOCAL_CHAN_I,
  input  wire        LOCAL_EXP_BIT_I,
  // backplane test path
  input  wire [31:0] BP_RX_I,
  input  wire        BP_BIT_STB_I,
  input  wire [7:0]  BP_CHAN_I,
  input  wire        BP_EXP_BIT_I
);

  // a 7.5 ns step rounds to two 4 ns cycles; the output marker trails
  // the chosen tap by one more cycle for its own register
  localparam LEAD = `BMO_ADV_LEAD_CYC;
  localparam STEP = `BMO_ADV_STEP_CYC;

  // register decode
  localparam RSEL_NONE = 2'h0;
  localparam RSEL_MEM  = 2'h1;
  localparam RSEL_LERR = 2'h2;
  localparam RSEL_BERR = 2'h3;

  // saturating increment, shared by both counters
  function [15:0] sat_inc;
    input [15:0] value;
    input        hit;
    begin
      if (hit && value != `BMO_ERR_MAX) begin
        sat_inc = value + 16'h0001;
      end else begin
        sat_inc = value;
      end
    end
  endfunction

  // maps a register offset to its storage slot; bit 3 marks a hit
  function [3:0] slot_of;
    input [7:0] addr;
    begin
      case (addr)
        `BMO_OFS_LOC_ADV_LO: slot_of = {1'b1, `BMO_SLOT_LOC_ADV_LO};
        `BMO_OFS_LOC_ADV_HI: slot_of = {1'b1, `BMO_SLOT_LOC_ADV_HI};
        `BMO_OFS_BP_ADV0:    slot_of = {1'b1, `BMO_SLOT_BP_ADV0};
        `BMO_OFS_BP_ADV1:    slot_of = {1'b1, `BMO_SLOT_BP_ADV0 + 3'h1};
        `BMO_OFS_BP_ADV2:    slot_of = {1'b1, `BMO_SLOT_BP_ADV0 + 3'h2};
        `BMO_OFS_BP_ADV3:    slot_of = {1'b1, `BMO_SLOT_BP_ADV0 + 3'h3};
        `BMO_OFS_LOC_SEL:    slot_of = {1'b1, `BMO_SLOT_LOC_SEL};
        `BMO_OFS_BP_SEL:     slot_of = {1'b1, `BMO_SLOT_BP_SEL};
        default:             slot_of = 4'h0;
      endcase
    end
  endfunction

  // pipeline tap that gives the advance wanted by a two-bit code
  function [2:0] adv_tap;
    input [1:0] code;
    begin
      adv_tap = LEAD[2:0] - (code * STEP[2:0]);
    end
  endfunction

  // one strobed bit on the chosen channel that disagrees with the pattern
  function err_hit_of;
    input       stb;
    input [7:0] chan;
    input [7:0] chan_sel;
    input       rx_bit;
    input       exp_bit;
    begin
      err_hit_of = stb && (chan == chan_sel) && (rx_bit != exp_bit);
    end
  endfunction

  // working copies of the writable registers
  reg  [31:0]  loc_adv;
  reg  [63:0]  bp_adv;
  reg  [15:0]  loc_sel;
  reg  [15:0]  bp_sel;

  // error counters
  reg  [15:0]  local_err_count;
  reg  [15:0]  bp_err_count;

  // read path
  reg  [1:0]   rd_kind;
  reg  [1:0]   next_rd_kind;
  wire [15:0]  mem_rd_data;

  // write decode
  wire [3:0]   wr_hit;
  wire [3:0]   rd_hit;
  wire         wr_mem;
  reg  [15:0]  wr_word;

  // frame advance pipeline
  reg  [LEAD:0] frame_pipe;

  // pin synchronisers
  reg  [15:0]  loc_rx_meta;
  reg  [15:0]  loc_rx_sync;
  reg  [31:0]  bp_rx_meta;
  reg  [31:0]  bp_rx_sync;

  // timing delayed by two cycles to meet the synchronised data
  reg  [1:0]   loc_stb_d;
  reg  [1:0]   loc_exp_d;
  reg  [15:0]  loc_chan_d;
  reg  [1:0]   bp_stb_d;
  reg  [1:0]   bp_exp_d;
  reg  [15:0]  bp_chan_d;

  // test-channel decisions
  wire [3:0]   local_test_stream_sel;
  wire [7:0]   local_test_channel_sel;
  wire [4:0]   bp_test_stream_sel;
  wire [7:0]   bp_test_channel_sel;
  wire         loc_err_hit;
  wire         bp_err_hit;
  wire         loc_clear;
  wire         bp_clear;

  integer      s;

  assign wr_hit = slot_of(REG_ADDR_I);
  assign rd_hit = wr_hit;
  assign wr_mem = REG_WR_I && wr_hit[3];

  // reserved select bits are stored and read back as zero
  always @* begin
    case (wr_hit[2:0])
      `BMO_SLOT_LOC_SEL: wr_word = REG_WDATA_I & `BMO_LOC_SEL_MASK;
      `BMO_SLOT_BP_SEL:  wr_word = REG_WDATA_I & `BMO_BP_SEL_MASK;
      default:           wr_word = REG_WDATA_I;
    endcase
  end

  // the store only answers reads; the datapath uses the working copies
  // below so that a read never competes with the frame logic
  bmo_regmem u_regmem (
    .clock_i   (CLOCK_I),
    .reset_n_i (RESET_N_I),
    .wr_i      (wr_mem),
    .wr_slot_i (wr_hit[2:0]),
    .wr_data_i (wr_word),
    .rd_slot_i (rd_hit[2:0]),
    .rd_data_o (mem_rd_data)
  );

  // working copies follow every write to the store
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      loc_adv <= {2{`BMO_RESET_WORD}};
      bp_adv  <= {4{`BMO_RESET_WORD}};
      loc_sel <= `BMO_RESET_WORD;
      bp_sel  <= `BMO_RESET_WORD;
    end else if (wr_mem) begin
      case (wr_hit[2:0])
        `BMO_SLOT_LOC_ADV_LO: loc_adv[15:0]  <= wr_word;
        `BMO_SLOT_LOC_ADV_HI: loc_adv[31:16] <= wr_word;
        3'h2:                 bp_adv[15:0]   <= wr_word;
        3'h3:                 bp_adv[31:16]  <= wr_word;
        3'h4:                 bp_adv[47:32]  <= wr_word;
        3'h5:                 bp_adv[63:48]  <= wr_word;
        `BMO_SLOT_LOC_SEL:    loc_sel        <= wr_word;
        `BMO_SLOT_BP_SEL:     bp_sel         <= wr_word;
        default:              loc_sel        <= loc_sel;
      endcase
    end
  end

  // read kind is chosen at the strobe, data appear the next cycle
  always @* begin
    if (!REG_RD_I) begin
      next_rd_kind = RSEL_NONE;
    end else if (REG_ADDR_I == `BMO_OFS_LOC_ERR) begin
      next_rd_kind = RSEL_LERR;
    end else if (REG_ADDR_I == `BMO_OFS_BP_ERR) begin
      next_rd_kind = RSEL_BERR;
    end else if (rd_hit[3]) begin
      next_rd_kind = RSEL_MEM;
    end else begin
      next_rd_kind = RSEL_NONE;
    end
  end

  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      rd_kind <= RSEL_NONE;
    end else begin
      rd_kind <= next_rd_kind;
    end
  end

  // counters are sampled at the strobe so the answer shows that cycle's value
  reg [15:0] cnt_snap;
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      cnt_snap <= `BMO_RESET_WORD;
    end else if (next_rd_kind == RSEL_LERR) begin
      cnt_snap <= local_err_count;
    end else begin
      cnt_snap <= bp_err_count;
    end
  end

  // unmapped reads and idle cycles answer zero
  always @* begin
    case (rd_kind)
      RSEL_MEM:  REG_RDATA_O = mem_rd_data;
      RSEL_LERR: REG_RDATA_O = cnt_snap;
      RSEL_BERR: REG_RDATA_O = cnt_snap;
      default:   REG_RDATA_O = `BMO_RESET_WORD;
    endcase
  end

  // the early frame marker runs down a short pipe; the last tap is the
  // aligned boundary and each code step picks a tap that much earlier
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      frame_pipe <= {(LEAD + 1){1'b0}};
    end else begin
      frame_pipe <= {frame_pipe[LEAD-1:0], FRAME_EARLY_I};
    end
  end

  // advance is a fixed time, so its fraction of a bit grows with the rate
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      LOCAL_FRAME_O <= 16'h0000;
      BP_FRAME_O    <= 32'h00000000;
    end else begin
      for (s = 0; s < 16; s = s + 1) begin
        LOCAL_FRAME_O[s] <= frame_pipe[adv_tap(loc_adv[2*s +: 2])];
      end
      for (s = 0; s < 32; s = s + 1) begin
        BP_FRAME_O[s] <= frame_pipe[adv_tap(bp_adv[2*s +: 2])];
      end
    end
  end

  // serial inputs come from pins: two flops before any use; a pin need
  // only carry its bit in the strobe cycle, since strobe, channel and
  // expected bit also pass two flops before the compare
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      loc_rx_meta <= 16'h0000;
      loc_rx_sync <= 16'h0000;
      bp_rx_meta  <= 32'h00000000;
      bp_rx_sync  <= 32'h00000000;
    end else begin
      loc_rx_meta <= LOCAL_RX_I;
      loc_rx_sync <= loc_rx_meta;
      bp_rx_meta  <= BP_RX_I;
      bp_rx_sync  <= bp_rx_meta;
    end
  end

  // strobe, channel and expected bit delayed to line up with the data
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      loc_stb_d  <= 2'h0;
      loc_exp_d  <= 2'h0;
      loc_chan_d <= 16'h0000;
      bp_stb_d   <= 2'h0;
      bp_exp_d   <= 2'h0;
      bp_chan_d  <= 16'h0000;
    end else begin
      loc_stb_d  <= {loc_stb_d[0], LOCAL_BIT_STB_I};
      loc_exp_d  <= {loc_exp_d[0], LOCAL_EXP_BIT_I};
      loc_chan_d <= {loc_chan_d[7:0], LOCAL_CHAN_I};
      bp_stb_d   <= {bp_stb_d[0], BP_BIT_STB_I};
      bp_exp_d   <= {bp_exp_d[0], BP_EXP_BIT_I};
      bp_chan_d  <= {bp_chan_d[7:0], BP_CHAN_I};
    end
  end

  assign local_test_stream_sel  = loc_sel[`BMO_LOC_STREAM_MSB:`BMO_LOC_STREAM_LSB];
  assign local_test_channel_sel = loc_sel[`BMO_CHAN_MSB:`BMO_CHAN_LSB];
  assign bp_test_stream_sel     = bp_sel[`BMO_BP_STREAM_MSB:`BMO_BP_STREAM_LSB];
  assign bp_test_channel_sel    = bp_sel[`BMO_CHAN_MSB:`BMO_CHAN_LSB];

  assign loc_err_hit = err_hit_of(loc_stb_d[1], loc_chan_d[15:8], local_test_channel_sel,
                                  loc_rx_sync[local_test_stream_sel], loc_exp_d[1]);
  assign bp_err_hit  = err_hit_of(bp_stb_d[1], bp_chan_d[15:8], bp_test_channel_sel,
                                  bp_rx_sync[bp_test_stream_sel], bp_exp_d[1]);

  // a new selection restarts the count of its side; software that wants
  // a running total must read the count before it moves the selection
  assign loc_clear = wr_mem && (wr_hit[2:0] == `BMO_SLOT_LOC_SEL);
  assign bp_clear  = wr_mem && (wr_hit[2:0] == `BMO_SLOT_BP_SEL);

  // an error in the clearing cycle is kept, so the set wins over the clear
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      local_err_count <= `BMO_RESET_WORD;
      bp_err_count    <= `BMO_RESET_WORD;
    end else begin
      if (loc_clear) begin
        local_err_count <= {15'h0000, loc_err_hit};
      end else begin
        local_err_count <= sat_inc(local_err_count, loc_err_hit);
      end
      if (bp_clear) begin
        bp_err_count <= {15'h0000, bp_err_hit};
      end else begin
        bp_err_count <= sat_inc(bp_err_count, bp_err_hit);
      end
    end
  end

endmodule // bmo_top

// ==== tb/bmo_props.sv ====
/* checker for bmo_top: register port, frame advance, counter clear.
   sees only the top ports; bound to every bmo_top */
module bmo_props (
  // clock and reset
  input wire        CLOCK_I,
  input wire        RESET_N_I,
  // watched ports
  input wire [7:0]  REG_ADDR_I,
  input wire [15:0] REG_WDATA_I,
  input wire        REG_WR_I,
  input wire        REG_RD_I,
  input wire [15:0] REG_RDATA_O,
  input wire        FRAME_EARLY_I,
  input wire [15:0] LOCAL_FRAME_O,
  input wire [31:0] BP_FRAME_O,
  input wire        LOCAL_BIT_STB_I
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hist;
  logic [1:0] lc;
  logic [1:0] bc;
  // shadow of stream 0 codes, so the lead can be looked up in the history
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      hist <= 8'h00;
      lc   <= 2'h0;
      bc   <= 2'h0;
    end else begin
      hist <= {hist[6:0], FRAME_EARLY_I};
      if (REG_WR_I && REG_ADDR_I == 8'h20)
        lc <= REG_WDATA_I[1:0];
      if (REG_WR_I && REG_ADDR_I == 8'h1c)
        bc <= REG_WDATA_I[1:0];
    end
  end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  chk_rd_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000)
    else $error("read data not idle");
  chk_adv_back: assert property (
    (REG_WR_I && REG_ADDR_I >= 8'h1c && REG_ADDR_I <= 8'h21) ##1
    (REG_RD_I && REG_ADDR_I == $past(REG_ADDR_I)) |=> REG_RDATA_O == $past(REG_WDATA_I, 2))
    else $error("advance word not read back");
  chk_loc_sel: assert property (
    (REG_WR_I && REG_ADDR_I == 8'h26) ##1 (REG_RD_I && REG_ADDR_I == 8'h26)
    |=> REG_RDATA_O == ($past(REG_WDATA_I, 2) & 16'h0fff))
    else $error("local select read back wrong");
  chk_bp_sel: assert property (
    (REG_WR_I && REG_ADDR_I == 8'h29) ##1 (REG_RD_I && REG_ADDR_I == 8'h29)
    |=> REG_RDATA_O == ($past(REG_WDATA_I, 2) & 16'h1fff))
    else $error("backplane select read back wrong");
  chk_unmapped_zero: assert property (REG_RD_I && REG_ADDR_I == 8'h30 |=> REG_RDATA_O == 16'h0)
    else $error("unmapped read not zero");
  chk_loc_lead: assert property (LOCAL_FRAME_O[0] == hist[3'd7 - {lc, 1'b0}])
    else $error("local frame lead wrong");
  chk_bp_lead: assert property (BP_FRAME_O[0] == hist[3'd7 - {bc, 1'b0}])
    else $error("backplane frame lead wrong");
  chk_sel_clears: assert property (
    (!LOCAL_BIT_STB_I)[*3] ##0 (REG_WR_I && REG_ADDR_I == 8'h26) ##1
    (REG_RD_I && REG_ADDR_I == 8'h27 && !LOCAL_BIT_STB_I) |=> REG_RDATA_O == 16'h0)
    else $error("select write did not clear count");
  cov_frame: cover property (LOCAL_FRAME_O[0] && lc == 2'h3);
  cov_sat: cover property (REG_RD_I && REG_ADDR_I == 8'h27 ##1 REG_RDATA_O == 16'hffff);
  cov_clear: cover property (REG_WR_I && REG_ADDR_I == 8'h26 ##1 REG_RD_I);
endmodule // bmo_props
bind bmo_top bmo_props chk (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .FRAME_EARLY_I(FRAME_EARLY_I),
  .LOCAL_FRAME_O(LOCAL_FRAME_O), .BP_FRAME_O(BP_FRAME_O),
  .LOCAL_BIT_STB_I(LOCAL_BIT_STB_I));

// ==== tb/bmo_far.sv ====
/* far-side stream source: bit strobes, channel number, pattern bit
   and pin data. runs on the core clock; mode 0 toggles without strobes, 1 slow, 2 hammer */
module bmo_far #(parameter int W = 16) (
  // control
  input  wire logic       clk_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       err_i,
  input  wire logic [7:0] ch_i,
  // stream side
  output logic [W-1:0]    rx_o = '0,
  output logic            stb_o = 1'b0,
  output logic [7:0]      chan_o = 8'h00,
  output logic            exp_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] lfsr = 7'h5a;
  logic [1:0] cnt = 2'h0;
  // outside mode 2 pins only move every fourth edge so a strobed bit stays put; mode 2 moves them every edge
  always @(posedge clk_i) begin
    cnt <= cnt + 2'h1;
    stb_o <= mode_i == 2'h2 || (mode_i == 2'h1 && cnt == 2'h0);
    if (mode_i == 2'h2) begin
      chan_o <= ch_i;
      rx_o <= {W{exp_o ^ err_i}};
    end else if (cnt == 2'h0 && mode_i == 2'h1) begin
      lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
      exp_o <= lfsr[6];
      chan_o <= {6'h00, chan_o[1:0] + 2'h1};
      rx_o <= {W{lfsr[6] ^ err_i}};
    end else if (cnt == 2'h0) begin
      rx_o <= ~rx_o;
      exp_o <= ~exp_o;
    end
  end
endmodule // bmo_far

// ==== tb/tb_top.sv ====
/* self-checking bench for bmo_top with two far-side sources.
   assumes the design answers reads one cycle after the strobe */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_d = 1'b0;
  logic        fe = 1'b0;
  logic        err = 1'b0;
  logic [1:0]  lmode = 2'h0;
  logic [1:0]  bmode = 2'h0;
  logic [7:0]  lch = 8'h00;
  logic [7:0]  bch = 8'h00;
  logic [3:0]  lst = 4'h0;
  logic [4:0]  bst = 5'h00;
  logic [15:0] lcnt = 16'h0;
  logic [15:0] bcnt = 16'h0;
  logic [15:0] rdata, lfr, lrx;
  logic [31:0] bfr, brx;
  logic        lstb, bstb, lexp, bexp;
  logic [7:0]  lchan, bchan;
  logic [15:0] expq[$];
  logic [15:0] v;
  int          fails = 0;
  int          comparisons = 0;
  integer      seed = 32'h58b57677;
  always #2 clk = ~clk;
  bmo_top uut (.CLOCK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .FRAME_EARLY_I(fe),
    .LOCAL_FRAME_O(lfr), .BP_FRAME_O(bfr), .LOCAL_RX_I(lrx), .LOCAL_BIT_STB_I(lstb),
    .LOCAL_CHAN_I(lchan), .LOCAL_EXP_BIT_I(lexp), .BP_RX_I(brx), .BP_BIT_STB_I(bstb),
    .BP_CHAN_I(bchan), .BP_EXP_BIT_I(bexp));
  bmo_far #(.W(16)) far_l (.clk_i(clk), .mode_i(lmode), .err_i(err), .ch_i(lch),
    .rx_o(lrx), .stb_o(lstb), .chan_o(lchan), .exp_o(lexp));
  bmo_far #(.W(32)) far_b (.clk_i(clk), .mode_i(bmode), .err_i(err), .ch_i(bch),
    .rx_o(brx), .stb_o(bstb), .chan_o(bchan), .exp_o(bexp));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    expq.push_back(e);
  endtask
  task automatic idle;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d && expq.size() == 0) check("queue", 1, 0);
    else if (rd_d) check("read data", rdata, expq.pop_front());
  end
  // expected counts, saturating, cleared by a select write
  always @(posedge clk) begin
    if (!rst_n || (wr && addr == 8'h26)) lcnt <= 16'h0;
    else if (lstb && lchan == lch && lrx[lst] != lexp && lcnt != 16'hffff) lcnt <= lcnt + 1'b1;
    if (!rst_n || (wr && addr == 8'h29)) bcnt <= 16'h0;
    else if (bstb && bchan == bch && brx[bst] != bexp && bcnt != 16'hffff) bcnt <= bcnt + 1'b1;
  end
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 8'h1c; a <= 8'h30; a++) rd_reg(a[7:0], 16'h0000);
    wr_reg(8'h30, $random(seed));
    wr_reg(8'h27, $random(seed));
    wr_reg(8'h2a, $random(seed));
    rd_reg(8'h30, 16'h0000);
    rd_reg(8'h27, 16'h0000);
    rd_reg(8'h2a, 16'h0000);
    for (int a = 8'h1c; a <= 8'h21; a++) begin
      v = $random(seed);
      wr_reg(a[7:0], v);
      rd_reg(a[7:0], v);
    end
    v = $random(seed);
    {lst, lch, bst, bch} = {v[11:8], 6'h00, v[1:0], v[15:11], 6'h00, v[3:2]};
    wr_reg(8'h26, {4'h0, lst, lch});
    rd_reg(8'h26, {4'h0, lst, lch});
    wr_reg(8'h29, {3'h0, bst, bch});
    rd_reg(8'h29, {3'h0, bst, bch});
    for (int c = 0; c < 4; c++) begin
      for (int a = 8'h1c; a <= 8'h21; a++) wr_reg(a[7:0], {8{c[1:0]}});
      idle;
      repeat (10) @(posedge clk);
      fe <= 1'b1;
      for (int k = 1; k <= 8; k++) begin
        @(posedge clk);
        fe <= 1'b0;
        #1;
        check("local frame", lfr, (k == 8 - 2 * c) ? 16'hffff : 16'h0);
        check("bp frame", bfr, (k == 8 - 2 * c) ? 32'hffffffff : 32'h0);
      end
    end
    @(posedge clk);
    err <= 1'b1;
    lmode <= 2'h1;
    bmode <= 2'h1;
    repeat (200) @(posedge clk);
    err <= 1'b0;
    repeat (100) @(posedge clk);
    lmode <= 2'h0;
    bmode <= 2'h0;
    repeat (8) @(posedge clk);
    rd_reg(8'h27, lcnt);
    rd_reg(8'h2a, bcnt);
    wr_reg(8'h26, {4'h0, lst, lch});
    rd_reg(8'h27, 16'h0000);
    wr_reg(8'h29, {3'h0, bst, bch});
    rd_reg(8'h2a, 16'h0000);
    idle;
    err <= 1'b1;
    lmode <= 2'h2;
    bmode <= 2'h2;
    repeat (66000) @(posedge clk);
    lmode <= 2'h0;
    bmode <= 2'h0;
    repeat (8) @(posedge clk);
    rd_reg(8'h27, 16'hffff);
    rd_reg(8'h2a, 16'hffff);
    idle;
    // a mid-run reset must bring codes and counts back to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(8'h20, 16'h0000);
    rd_reg(8'h2a, 16'h0000);
    idle;
    repeat (4) @(posedge clk);
    tally_and_finish;
  end
endmodule // tb_top
